/* vrs_defs.svh */
`ifndef VRS_DEFS_SVH
`define VRS_DEFS_SVH
// Object indices of the process-data map
`define VRS_IDX_STATE_WORD   16'h6041
`define VRS_IDX_TOL_BAND     16'h606D
`define VRS_IDX_TOL_DWELL    16'h606E
// Drive state word bit positions
`define VRS_BIT_READY        0
`define VRS_BIT_SWITCHED_ON  1
`define VRS_BIT_OP_ENABLED   2
`define VRS_BIT_FAULT        3
`define VRS_BIT_POWER        4
`define VRS_BIT_QUICK_HALT   5
`define VRS_BIT_SW_DISABLED  6
`define VRS_BIT_WARNING      7
`define VRS_BIT_REMOTE       9
`define VRS_BIT_VEL_REACHED  10
`define VRS_BIT_INT_LIMIT    11
`define VRS_BIT_SPEED_ZERO   12
`define VRS_BIT_SLIP_ERR     13
// Reset values
`define VRS_RST_TOL_BAND     16'h0000
`define VRS_RST_TOL_DWELL    16'h0000
// Dwell unit is 1 ms; clock 125 MHz
`define VRS_DWELL_UNIT_NS    1000000
`define VRS_CLK_PERIOD_NS    8
`define VRS_CYC_PER_MS       (`VRS_DWELL_UNIT_NS / `VRS_CLK_PERIOD_NS)
`endif

/* vrs_pkg.sv */
package vrs_pkg;
  // Drive condition flags from the rest of the drive
  typedef struct packed {
    logic ready;
    logic switched_on;
    logic op_enabled;
    logic fault;
    logic power_present_flag;
    logic quick_halt_flag;
    logic sw_disabled;
    logic warning;
    logic remote_flag;
    logic int_limit;
    logic speed_zero;
  } vrs_cond_s;
  // Dwell tracker states
  typedef enum logic [2:0] {
    VRS_OUT   = 3'b001,
    VRS_DWELL = 3'b010,
    VRS_IN    = 3'b100
  } vrs_state_e;
  typedef logic [15:0] vrs_word_t;
endpackage

/* vrs_ms_tick.sv */
`timescale 1ns/1ps
`include "vrs_defs.svh"
// Divider giving a one-cycle pulse every millisecond
module vrs_ms_tick #(
  parameter int CYC_PER_TICK = `VRS_CYC_PER_MS
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic clear_i,
  output logic      tick_o
);
  localparam int CW = $clog2(CYC_PER_TICK + 1);
  logic [CW-1:0] cnt_r;   // Cycle count
  logic [CW-1:0] cnt_nxt; // Next count
  logic          tick_nxt;

  initial begin
    if (CYC_PER_TICK < 2) $error("CYC_PER_TICK must be at least 2");
  end

  // Restart on clear so the first tick is a full period away
  always_comb begin
    cnt_nxt  = cnt_r + CW'(1);
    tick_nxt = 1'b0;
    if (clear_i) begin
      cnt_nxt = '0;
    end else if (cnt_r == CW'(CYC_PER_TICK - 1)) begin
      cnt_nxt  = '0;
      tick_nxt = 1'b1;
    end
  end

  // Register only
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_o <= tick_nxt;
    end
  end
endmodule

/* vrs_status.sv */
`timescale 1ns/1ps
`include "vrs_defs.svh"
// Operation
// - Read-only 16-bit drive state word output
// - Bit 10 set after in-band dwell
// - Bit 10 cleared when deviation leaves band
// - Halt off: bit 10 means speed reached
// - Halt on: bit 10 means speed reached and axis stopped
// - Bit 13 slippage error not implemented
// - Dwell time sets in-band interval
module vrs_status
  import vrs_pkg::*;
#(
  parameter int VEL_W        = 32,
  parameter int CYC_PER_MS   = `VRS_CYC_PER_MS
) (
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic signed [VEL_W-1:0] target_vel_i,   // Commanded speed
  input  wire logic signed [VEL_W-1:0] vel_offset_i,   // Speed bias
  input  wire logic signed [VEL_W-1:0] actual_vel_i,   // Measured speed
  input  wire logic                    halt_i,         // Stop request from control word
  input  wire vrs_cond_s               cond_i,         // Other drive flags
  input  wire logic                    band_wr_i,      // Write strobe, tolerance band
  input  wire logic                    dwell_wr_i,     // Write strobe, dwell time
  input  wire vrs_word_t               wr_data_i,      // Written value
  output vrs_word_t                    state_word_o,   // Drive state word
  output vrs_word_t                    tol_band_o,     // Band readback
  output vrs_word_t                    tol_dwell_o     // Dwell readback
);
  initial begin
    if (VEL_W < 17 || VEL_W > 62) $error("VEL_W out of range");
    if (CYC_PER_MS < 2) $error("CYC_PER_MS must be at least 2");
  end

  // Parameter registers
  vrs_word_t band_r, band_nxt;    // Tolerance band, command units/s
  vrs_word_t dwell_r, dwell_nxt;  // Dwell, milliseconds

  // Host writes; full unsigned 16-bit range accepted as is
  always_comb begin
    band_nxt  = band_r;
    dwell_nxt = dwell_r;
    if (band_wr_i) begin
      band_nxt = wr_data_i;
    end
    if (dwell_wr_i) begin
      dwell_nxt = wr_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      band_r  <= `VRS_RST_TOL_BAND;
      dwell_r <= `VRS_RST_TOL_DWELL;
    end else begin
      band_r  <= band_nxt;
      dwell_r <= dwell_nxt;
    end
  end

  // Deviation: widened two bits so sum and difference never wrap
  localparam int DW = VEL_W + 2;
  logic signed [DW-1:0] cmd_sum;  // Target plus bias
  logic signed [DW-1:0] dev;      // Commanded minus measured
  logic        [DW-1:0] dev_abs;  // Magnitude
  logic                 in_band;  // Deviation within band

  always_comb begin
    cmd_sum = DW'(target_vel_i) + DW'(vel_offset_i);
    dev     = cmd_sum - DW'(actual_vel_i);
    dev_abs = dev[DW-1] ? DW'(-dev) : DW'(dev);
    in_band = (dev_abs <= DW'(band_r));
  end

  // Millisecond enable, held in phase with the start of dwell
  logic ms_tick;   // One pulse per ms
  logic tick_clr;  // Restart divider

  vrs_ms_tick #(
    .CYC_PER_TICK (CYC_PER_MS)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .clear_i    (tick_clr),
    .tick_o     (ms_tick)
  );

  // Dwell tracker
  vrs_state_e st_r, st_nxt;       // Tracker state
  vrs_word_t  ms_r, ms_nxt;       // Elapsed ms in band
  logic       reach_r, reach_nxt; // Velocity reached

  // Leaving band always returns to OUT, which zeroes the dwell count
  always_comb begin
    st_nxt    = st_r;
    ms_nxt    = ms_r;
    reach_nxt = reach_r;
    tick_clr  = 1'b0;
    case (st_r)
      VRS_OUT: begin
        reach_nxt = 1'b0;
        tick_clr  = 1'b1;
        ms_nxt    = '0;
        if (in_band) begin
          if (dwell_r == 16'h0000) begin
            st_nxt    = VRS_IN; // Zero dwell: reached at once
            reach_nxt = 1'b1;
          end else begin
            st_nxt = VRS_DWELL;
          end
        end
      end
      VRS_DWELL: begin
        if (!in_band) begin
          st_nxt = VRS_OUT;
          ms_nxt = '0;
        end else if (ms_tick) begin
          ms_nxt = ms_r + 16'h0001;
          if (ms_nxt >= dwell_r) begin
            st_nxt    = VRS_IN;
            reach_nxt = 1'b1;
          end
        end
      end
      VRS_IN: begin
        if (!in_band) begin
          st_nxt    = VRS_OUT;
          reach_nxt = 1'b0;
          ms_nxt    = '0;
        end
      end
      default: begin
        st_nxt    = VRS_OUT;
        reach_nxt = 1'b0;
        ms_nxt    = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_r    <= VRS_OUT;
      ms_r    <= '0;
      reach_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      ms_r    <= ms_nxt;
      reach_r <= reach_nxt;
    end
  end

  // State word assembly
  vrs_word_t sw_nxt; // Next state word

  // Under halt the reached flag is also gated by cond_i.speed_zero, so bit 10
  // reports a stopped axis only when in band as well; halt has its own path.
  always_comb begin
    sw_nxt = '0; // Reserved bits and bit 13 read zero
    sw_nxt[`VRS_BIT_READY]       = cond_i.ready;
    sw_nxt[`VRS_BIT_SWITCHED_ON] = cond_i.switched_on;
    sw_nxt[`VRS_BIT_OP_ENABLED]  = cond_i.op_enabled;
    sw_nxt[`VRS_BIT_FAULT]       = cond_i.fault;
    sw_nxt[`VRS_BIT_POWER]       = cond_i.power_present_flag;
    sw_nxt[`VRS_BIT_QUICK_HALT]  = cond_i.quick_halt_flag;
    sw_nxt[`VRS_BIT_SW_DISABLED] = cond_i.sw_disabled;
    sw_nxt[`VRS_BIT_WARNING]     = cond_i.warning;
    sw_nxt[`VRS_BIT_REMOTE]      = cond_i.remote_flag;
    sw_nxt[`VRS_BIT_INT_LIMIT]   = cond_i.int_limit;
    sw_nxt[`VRS_BIT_SPEED_ZERO]  = cond_i.speed_zero;
    if (halt_i) begin
      sw_nxt[`VRS_BIT_VEL_REACHED] = reach_nxt && cond_i.speed_zero;
    end else begin
      sw_nxt[`VRS_BIT_VEL_REACHED] = reach_nxt;
    end
    sw_nxt[`VRS_BIT_SLIP_ERR] = 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_word_o <= '0;
      tol_band_o   <= `VRS_RST_TOL_BAND;
      tol_dwell_o  <= `VRS_RST_TOL_DWELL;
    end else begin
      state_word_o <= sw_nxt;
      tol_band_o   <= band_nxt;
      tol_dwell_o  <= dwell_nxt;
    end
  end

  // Checks
  AST_SLIP_ZERO: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_word_o[`VRS_BIT_SLIP_ERR] == 1'b0)
    else $error("bit 13 set");
  AST_OUT_CLEARS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !in_band |=> !state_word_o[`VRS_BIT_VEL_REACHED])
    else $error("bit 10 set out of band");
  AST_DWELL_RESTART: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == VRS_DWELL && !in_band) |=> (ms_r == 16'h0000 && st_r == VRS_OUT))
    else $error("dwell not restarted");
  AST_NO_EARLY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $rose(reach_r) |-> (ms_r >= $past(dwell_r)))
    else $error("reached before dwell");
  AST_REACH_AFTER_DWELL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == VRS_DWELL && in_band && ms_tick && ms_r + 16'h0001 >= dwell_r) |=> reach_r)
    else $error("reached not set");
  // Zero dwell must not wait for a divider tick
  AST_ZERO_DWELL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_r == VRS_OUT && in_band && dwell_r == 16'h0000) |=> reach_r)
    else $error("reached not set at zero dwell");
  AST_HALT_STOP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (halt_i && !cond_i.speed_zero) |=> !state_word_o[`VRS_BIT_VEL_REACHED])
    else $error("bit 10 under halt while moving");
  AST_NOHALT_MIRROR: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !halt_i |=> state_word_o[`VRS_BIT_VEL_REACHED] == reach_r)
    else $error("bit 10 mismatch");
  AST_BAND_WRITE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    band_wr_i |=> tol_band_o == $past(wr_data_i))
    else $error("band not written");
  AST_DWELL_WRITE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    dwell_wr_i |=> tol_dwell_o == $past(wr_data_i))
    else $error("dwell not written");
  AST_RESERVED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    state_word_o[15:14] == 2'b00 && state_word_o[8] == 1'b0)
    else $error("reserved set");
endmodule

/* vrs_host.sv */
`timescale 1ns/1ps
// Host controller side: issues parameter writes over process data
module vrs_host
  import vrs_pkg::*;
(
  input  wire logic core_clk_i,
  output logic      band_wr_o,
  output logic      dwell_wr_o,
  output vrs_word_t wr_data_o
);
  // Idle bus: no strobe, data not yet meaningful
  initial begin
    band_wr_o  = 1'b0;
    dwell_wr_o = 1'b0;
    wr_data_o  = 16'h0000;
  end

  // One-cycle strobe around a rising edge; any 16-bit value is legal
  task automatic write(input logic sel_dwell, input vrs_word_t val);
    @(negedge core_clk_i);
    band_wr_o  = ~sel_dwell;
    dwell_wr_o = sel_dwell;
    wr_data_o  = val;
    @(negedge core_clk_i);
    band_wr_o  = 1'b0;
    dwell_wr_o = 1'b0;
    // Stale data inverted so a missed strobe cannot pass for a hit
    wr_data_o  = ~val;
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench
  import vrs_pkg::*;
;
  logic               core_clk_i;
  logic               sys_rst_i;
  logic signed [31:0] tgt;        // Commanded speed
  logic signed [31:0] ofs;        // Speed bias
  logic signed [31:0] act;        // Measured speed
  logic               halt;       // Stop request
  vrs_cond_s          cond;       // Other drive flags
  logic               band_wr;
  logic               dwell_wr;
  vrs_word_t          wr_data;
  vrs_word_t          word;
  vrs_word_t          band;
  vrs_word_t          dwell;
  int                 errors;
  int                 n_compared;

  // Short millisecond so dwell runs stay brief
  vrs_status #(.CYC_PER_MS(4)) DUT (
    .core_clk_i   (core_clk_i),
    .sys_rst_i    (sys_rst_i),
    .target_vel_i (tgt),
    .vel_offset_i (ofs),
    .actual_vel_i (act),
    .halt_i       (halt),
    .cond_i       (cond),
    .band_wr_i    (band_wr),
    .dwell_wr_i   (dwell_wr),
    .wr_data_i    (wr_data),
    .state_word_o (word),
    .tol_band_o   (band),
    .tol_dwell_o  (dwell)
  );

  vrs_host host (
    .core_clk_i (core_clk_i),
    .band_wr_o  (band_wr),
    .dwell_wr_o (dwell_wr),
    .wr_data_o  (wr_data)
  );

  // 125 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // Single place that ends the run
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Four-state compare so an unknown never matches
  task automatic check(input vrs_word_t seen, input vrs_word_t exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs move on falling edges only
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // Bounded wait for the reached flag; a miss closes the run
  task automatic wait_set(input int bound);
    for (int i = 0; i < bound; i++) begin
      @(negedge core_clk_i);
      if (word[10] === 1'b1) begin
        return;
      end
    end
    errors++;
    $display("unexpected reached_timeout: expected 1 seen %b", word[10]);
    print_verdict();
  endtask

  // Main sequence
  initial begin
    errors     = 0;
    n_compared = 0;
    sys_rst_i  = 1'b1;
    tgt        = 32'h00000064;
    ofs        = 32'h00000000;
    act        = 32'h000000C8;
    halt       = 1'b0;
    cond       = '0;
    idle(2);
    check(word, 16'h0000, "word_reset");
    check(band, 16'h0000, "band_reset");
    check(dwell, 16'h0000, "dwell_reset");
    sys_rst_i = 1'b0;
    // Boundary values, then working settings
    host.write(1'b0, 16'hFFFF);
    check(band, 16'hFFFF, "band_max");
    host.write(1'b1, 16'hFFFF);
    check(dwell, 16'hFFFF, "dwell_max");
    host.write(1'b0, 16'h000A);
    host.write(1'b1, 16'h0000);
    check(band, 16'h000A, "band_ten");
    check(dwell, 16'h0000, "dwell_zero");
    // All flags on, speed far out of band; bits 8 and 13..15 stay low
    cond = '1;
    idle(2);
    check(word, 16'h1AFF, "flags_all");
    cond = '0;
    // Deviation exactly at the band edge, both signs
    ofs = 32'hFFFFFFFB;
    act = 32'h00000055;
    idle(2);
    check(word, 16'h0400, "edge_pos");
    act = 32'h00000054;
    idle(2);
    check(word, 16'h0000, "just_out");
    act = 32'h00000069;
    idle(2);
    check(word, 16'h0400, "edge_neg");
    // Stop request: flag waits for standstill
    halt = 1'b1;
    idle(2);
    check(word, 16'h0000, "halt_moving");
    cond.speed_zero = 1'b1;
    idle(2);
    check(word, 16'h1400, "halt_stopped");
    halt            = 1'b0;
    cond.speed_zero = 1'b0;
    idle(2);
    check(word, 16'h0400, "halt_released");
    // Dwell of 2 ms: flag holds off, then rises
    act = 32'h00000000;
    host.write(1'b1, 16'h0002);
    act = 32'h0000005F;
    idle(6);
    check({15'h0000, word[10]}, 16'h0000, "dwell_early");
    wait_set(10);
    act = 32'h00000000;
    idle(2);
    check({15'h0000, word[10]}, 16'h0000, "dwell_left");
    // One out-of-band cycle mid-dwell must restart the count
    act = 32'h0000005F;
    idle(5);
    act = 32'h00000000;
    idle(1);
    act = 32'h0000005F;
    idle(6);
    check({15'h0000, word[10]}, 16'h0000, "dwell_restart");
    wait_set(10);
    print_verdict();
  end
endmodule
